// ---- rtl/rio_line_ctrl.sv ----
// I/O line role control, sampling, line passing and PWM outputs
`timescale 1ns/100ps
`default_nettype none
`include "rio_map.svh"
module rio_line_ctrl
  import rio_pkg::*;
#(
  parameter int unsigned MS_CYCLES  = `RIO_MS_CYCLES,
  parameter int unsigned TMO_CYCLES = `RIO_TMO_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [4:0]  cmd_id,
  input  wire logic [63:0] cmd_wdata,
  output logic             resp_valid,
  output logic             resp_error,
  output logic [63:0]      resp_rdata,
  input  wire logic [8:0]  line_in,
  input  wire logic [59:0] adc_in,
  output logic [7:0]       line_out,
  output logic [7:0]       line_oe,
  input  wire logic        associated,
  input  wire logic        serial_rx_full,
  input  wire logic        serial_tx_active,
  output logic             rts_hold,
  output logic [1:0]       api_mode,
  input  wire logic        rx_pkt_valid,
  input  wire logic [9:0]  rx_rssi,
  input  wire logic        rx_io_valid,
  input  wire logic [63:0] rx_io_src,
  input  wire logic [7:0]  rx_io_dout,
  input  wire logic        rx_io_pwm_valid,
  input  wire logic [19:0] rx_io_pwm,
  output logic             fwd_valid,
  output logic             fwd_escaped,
  output logic [7:0]       fwd_dio,
  output logic             sample_valid,
  output logic             sample_forced,
  output logic             sample_dig_only,
  output logic [8:0]       sample_dio,
  output logic [59:0]      sample_adc,
  output logic             tx_send,
  output logic [1:0]       pwm_out
);

  // Stored parameters
  rio_cfg_t    cfg_q [9];
  logic        fwd_en_q;
  logic [7:0]  samp_tx_q;
  logic [7:0]  chg_mask_q;
  logic [15:0] samp_int_q;
  logic [63:0] bound_q;
  logic [7:0]  tmo_q [8];
  logic [1:0]  pwm_fn_q [2];
  logic [9:0]  pwm_lvl_q [2];
  logic [7:0]  pwm_tmo_q;
  logic [7:0]  rssi_tmr_q;
  logic [1:0]  api_q;
  logic [7:0]  io_lvl_q;

  // Command decode
  wire wr      = cmd_valid & cmd_write;
  wire is_line = cmd_id <= `RIO_ID_LINE_LAST;
  wire is_tmo  = cmd_id[4:3] == 2'b10;
  wire [3:0] line_sel = cmd_id[3:0];
  wire [2:0] v3 = cmd_wdata[2:0];
  wire hi_zero3  = cmd_wdata[63:3] == '0;
  wire hi_zero8  = cmd_wdata[63:8] == '0;
  wire hi_zero16 = cmd_wdata[63:16] == '0;

  // Allowed setting per line; others are refused
  function automatic logic cfg_ok(input logic [3:0] n, input logic [2:0] v);
    logic dio;
    dio = (v == `RIO_CFG_DI) || (v == `RIO_CFG_DO_LO) || (v == `RIO_CFG_DO_HI);
    if (n == 4'd8) cfg_ok = (v == `RIO_CFG_OFF) || (v == `RIO_CFG_DI);
    else if (n == 4'd7) cfg_ok = v != `RIO_CFG_ADC;
    else if (n == 4'd6) cfg_ok = (v <= `RIO_CFG_SPECIAL) || dio;
    else if (n == 4'd5) cfg_ok = v <= `RIO_CFG_DO_HI;
    else cfg_ok = (v == `RIO_CFG_OFF) || (v == `RIO_CFG_ADC) || dio;
  endfunction : cfg_ok

  // Range check of each write; unknown identifiers are refused too
  wire val_ok =
    is_line ? (hi_zero3 && cfg_ok(line_sel, v3)) :
    (cmd_id == `RIO_ID_FWD_EN)  ? (cmd_wdata[63:1] == '0) :
    (cmd_id == `RIO_ID_SAMP_TX) ? (hi_zero8 && cmd_wdata[7:0] != 8'h00) :
    (cmd_id == `RIO_ID_OUT_LVL || cmd_id == `RIO_ID_CHG_MASK || is_tmo ||
     cmd_id == `RIO_ID_PWM_TMO || cmd_id == `RIO_ID_RSSI_TMR) ? hi_zero8 :
    (cmd_id == `RIO_ID_SAMP_INT) ? hi_zero16 :
    (cmd_id == `RIO_ID_BOUND_ADR) ? 1'b1 :
    (cmd_id == `RIO_ID_PWM_A_FN || cmd_id == `RIO_ID_PWM_B_FN ||
     cmd_id == `RIO_ID_API_MODE) ? (cmd_wdata[63:2] == '0 &&
                                    cmd_wdata[1:0] <= 2'h2) :
    (cmd_id == `RIO_ID_PWM_A_LVL || cmd_id == `RIO_ID_PWM_B_LVL) ?
      (cmd_wdata[63:10] == '0) : 1'b0;
  wire wr_ok = wr && val_ok && (cmd_id != `RIO_ID_FORCE);

  // Enabled inputs, used by every sample kind
  logic [8:0] di_en;
  logic [5:0] adc_en;
  logic [59:0] sample_adc_d;
  genvar g;
  for (g = 0; g < 9; g++) begin : g_en
    assign di_en[g] = cfg_q[g] == `RIO_CFG_DI;
    if (g < 6) begin : g_adc
      assign adc_en[g] = cfg_q[g] == `RIO_CFG_ADC;
      assign sample_adc_d[g*10 +: 10] = adc_en[g] ? adc_in[g*10 +: 10]
                                                  : 10'h000;
    end
  end
  wire any_in = (di_en != 9'h000) || (adc_en != 6'h00);
  wire force_cmd = cmd_valid && !cmd_write && cmd_id == `RIO_ID_FORCE;

  // Address filter for received I/O packets
  wire bound_block = bound_q == `RIO_RST_BOUND;
  wire bound_any   = bound_q == `RIO_ANY_SOURCE;
  wire accept = !bound_block && (bound_any || bound_q == rx_io_src);
  wire io_take  = rx_io_valid && accept;
  wire pwm_take = rx_io_pwm_valid && accept;

  // Millisecond and 100 ms ticks; long counts are parameters
  logic [31:0] ms_cnt_q, tmo_cnt_q;
  wire ms_tick  = ms_cnt_q == 32'(MS_CYCLES - 1);
  wire tmo_tick = tmo_cnt_q == 32'(TMO_CYCLES - 1);
  always_ff @(posedge clock) begin
    ms_cnt_q  <= (rst || ms_tick) ? 32'h0 : ms_cnt_q + 32'h1;
    tmo_cnt_q <= (rst || tmo_tick) ? 32'h0 : tmo_cnt_q + 32'h1;
  end

  // Parameter storage; a line setting also reloads its command level
  for (g = 0; g < 9; g++) begin : g_cfg
    wire hit = wr_ok && is_line && line_sel == 4'(g);
    always_ff @(posedge clock) begin
      if (rst) cfg_q[g] <= (g == 7) ? `RIO_RST_LINE7 :
                           (g == 5) ? `RIO_RST_LINE5 : `RIO_CFG_OFF;
      else if (hit) cfg_q[g] <= v3;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_en_q   <= `RIO_RST_FWD_EN;
      samp_tx_q  <= `RIO_RST_SAMP_TX;
      chg_mask_q <= 8'h00;
      samp_int_q <= 16'h0000;
      bound_q    <= `RIO_RST_BOUND;
      pwm_fn_q[0] <= `RIO_RST_PWM_A_FN;
      pwm_fn_q[1] <= `RIO_PWM_OFF;
      pwm_tmo_q  <= `RIO_RST_TMO;
      rssi_tmr_q <= `RIO_RST_RSSI_TMR;
      api_q      <= 2'h0;
    end else if (wr_ok) begin
      if (cmd_id == `RIO_ID_FWD_EN)    fwd_en_q   <= cmd_wdata[0];
      if (cmd_id == `RIO_ID_SAMP_TX)   samp_tx_q  <= cmd_wdata[7:0];
      if (cmd_id == `RIO_ID_CHG_MASK)  chg_mask_q <= cmd_wdata[7:0];
      if (cmd_id == `RIO_ID_SAMP_INT)  samp_int_q <= cmd_wdata[15:0];
      if (cmd_id == `RIO_ID_BOUND_ADR) bound_q    <= cmd_wdata;
      if (cmd_id == `RIO_ID_PWM_A_FN)  pwm_fn_q[0] <= cmd_wdata[1:0];
      if (cmd_id == `RIO_ID_PWM_B_FN)  pwm_fn_q[1] <= cmd_wdata[1:0];
      if (cmd_id == `RIO_ID_PWM_TMO)   pwm_tmo_q  <= cmd_wdata[7:0];
      if (cmd_id == `RIO_ID_RSSI_TMR)  rssi_tmr_q <= cmd_wdata[7:0];
      if (cmd_id == `RIO_ID_API_MODE)  api_q      <= cmd_wdata[1:0];
    end
  end

  // Per-output line passing with its own timeout
  logic [7:0] pass_act_q, pass_lvl_q;
  logic [7:0] pass_cnt_q [8];
  for (g = 0; g < 8; g++) begin : g_pass
    wire is_do   = cfg_q[g] == `RIO_CFG_DO_LO || cfg_q[g] == `RIO_CFG_DO_HI;
    wire dflt    = cfg_q[g] == `RIO_CFG_DO_HI;
    wire cfg_hit = wr_ok && is_line && line_sel == 4'(g);
    wire tmo_hit = wr_ok && is_tmo && cmd_id[2:0] == 3'(g);
    wire lvl_hit = wr_ok && cmd_id == `RIO_ID_OUT_LVL;
    always_ff @(posedge clock) begin
      if (rst) tmo_q[g] <= `RIO_RST_TMO;
      else if (tmo_hit) tmo_q[g] <= cmd_wdata[7:0];
    end
    // Command-mode level, re-seeded when the line setting changes
    always_ff @(posedge clock) begin
      if (rst) io_lvl_q[g] <= 1'b0;
      else if (cfg_hit) io_lvl_q[g] <= v3 == `RIO_CFG_DO_HI;
      else if (lvl_hit) io_lvl_q[g] <= cmd_wdata[g];
    end
    // Every accepted packet reloads the timer; expiry restores the command level
    always_ff @(posedge clock) begin
      if (rst || cfg_hit || !is_do) begin
        pass_act_q[g] <= 1'b0;
        pass_lvl_q[g] <= 1'b0;
        pass_cnt_q[g] <= 8'h00;
      end else if (io_take) begin
        pass_lvl_q[g] <= rx_io_dout[g];
        pass_act_q[g] <= rx_io_dout[g] != dflt;
        pass_cnt_q[g] <= tmo_q[g];
      end else if (pass_act_q[g] && tmo_tick) begin
        if (pass_cnt_q[g] == 8'h00) pass_act_q[g] <= 1'b0;
        else pass_cnt_q[g] <= pass_cnt_q[g] - 8'h01;
      end
    end
  end

  // Line drivers; the association blink uses the 100 ms tick
  logic blink_q;
  always_ff @(posedge clock) begin
    if (rst || !associated) blink_q <= 1'b0;
    else if (tmo_tick) blink_q <= !blink_q;
  end
  logic [7:0] out_d, oe_d;
  for (g = 0; g < 8; g++) begin : g_drv
    wire lvl = pass_act_q[g] ? pass_lvl_q[g] : io_lvl_q[g];
    wire do_mode = cfg_q[g] == `RIO_CFG_DO_LO || cfg_q[g] == `RIO_CFG_DO_HI;
    wire sp = cfg_q[g] == `RIO_CFG_SPECIAL;
    if (g == 7) begin : g_l7
      // Clear-to-send is active low: high asks the host to hold off
      assign oe_d[g]  = do_mode || sp || cfg_q[g][2:1] == 2'b11;
      assign out_d[g] = do_mode ? lvl : sp ? serial_rx_full :
                        (cfg_q[g] == `RIO_CFG_TXEN_HI) ? serial_tx_active
                                                       : !serial_tx_active;
    end else if (g == 5) begin : g_l5
      assign oe_d[g]  = do_mode || sp;
      assign out_d[g] = do_mode ? lvl : (sp && blink_q);
    end else begin : g_lx
      assign oe_d[g]  = do_mode;
      assign out_d[g] = do_mode && lvl;
    end
  end
  always_ff @(posedge clock) begin
    line_out <= rst ? 8'h00 : out_d;
    line_oe  <= rst ? 8'h00 : oe_d;
    rts_hold <= !rst && cfg_q[6] == `RIO_CFG_SPECIAL && line_in[6];
  end
  assign api_mode = api_q;

  // PWM levels: both pins share one timeout, started only by passed levels
  logic       pwm_act_q, rssi_act_q;
  logic [7:0] pwm_cnt_q, rssi_cnt_q;
  logic [9:0] rssi_q, pwm_phase_q;
  wire pwm_nz = rx_io_pwm != 20'h00000;
  wire pwm_exp = pwm_act_q && tmo_tick && pwm_cnt_q == 8'h00;
  for (g = 0; g < 2; g++) begin : g_pwm
    wire hit = wr_ok && cmd_id == 5'(`RIO_ID_PWM_A_LVL + g);
    // A packet landing on the expiry tick wins, so its level is kept
    always_ff @(posedge clock) begin
      if (rst) pwm_lvl_q[g] <= 10'h000;
      else if (pwm_take) pwm_lvl_q[g] <= rx_io_pwm[g*10 +: 10];
      else if (pwm_exp) pwm_lvl_q[g] <= 10'h000;
      else if (hit) pwm_lvl_q[g] <= cmd_wdata[9:0];
    end
    wire duty = (pwm_fn_q[g] == `RIO_PWM_OUT && pwm_phase_q < pwm_lvl_q[g]) ||
                (pwm_fn_q[g] == `RIO_PWM_RSSI && rssi_act_q &&
                 pwm_phase_q < rssi_q);
    always_ff @(posedge clock) pwm_out[g] <= !rst && duty;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_act_q <= 1'b0;
      pwm_cnt_q <= 8'h00;
    end else if (pwm_take) begin
      pwm_act_q <= pwm_nz;
      pwm_cnt_q <= pwm_tmo_q;
    end else if (pwm_exp) pwm_act_q <= 1'b0;
    else if (pwm_act_q && tmo_tick) pwm_cnt_q <= pwm_cnt_q - 8'h01;
  end
  // Signal-strength duty follows every packet until its timer runs out
  always_ff @(posedge clock) begin
    pwm_phase_q <= rst ? 10'h000 : pwm_phase_q + 10'h001;
    if (rst) begin
      rssi_act_q <= 1'b0;
      rssi_cnt_q <= 8'h00;
      rssi_q     <= 10'h000;
    end else if (rx_pkt_valid) begin
      rssi_act_q <= 1'b1;
      rssi_cnt_q <= rssi_tmr_q;
      rssi_q     <= rx_rssi;
    end else if (rssi_act_q && tmo_tick) begin
      if (rssi_cnt_q == 8'h00) rssi_act_q <= 1'b0;
      else rssi_cnt_q <= rssi_cnt_q - 8'h01;
    end
  end

  // Received I/O data goes out as an API frame whatever the API mode
  always_ff @(posedge clock) begin
    fwd_valid   <= !rst && rx_io_valid && fwd_en_q;
    fwd_escaped <= !rst && api_q == `RIO_API_ESC;
    fwd_dio     <= rst ? 8'h00 : rx_io_dout;
  end

  // Change detect: flush the queue, then a digital-only sample
  rio_chg_t    st_q;
  logic [7:0]  prev_q, samp_n_q;
  logic [15:0] int_cnt_q;
  wire [7:0] chg = (line_in[7:0] ^ prev_q) & chg_mask_q & di_en[7:0];
  wire per_due = samp_int_q != 16'h0000 && ms_tick &&
                 int_cnt_q + 16'h0001 >= samp_int_q;
  wire per_take = st_q == RIO_IDLE && chg == 8'h00 && per_due && any_in;
  wire batch_full = samp_n_q + 8'h01 >= samp_tx_q;
  always_ff @(posedge clock) begin
    prev_q <= rst ? 8'h00 : line_in[7:0];
    if (rst || samp_int_q == 16'h0000 || per_due) int_cnt_q <= 16'h0000;
    else if (ms_tick) int_cnt_q <= int_cnt_q + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (rst) st_q <= RIO_IDLE;
    else begin
      case (st_q)
        RIO_IDLE:  if (chg != 8'h00) st_q <= RIO_FLUSH;
        RIO_FLUSH: st_q <= RIO_SEND;
        RIO_SEND:  st_q <= RIO_IDLE;
        default:   st_q <= RIO_IDLE;
      endcase
    end
  end
  // Sample output and batch counter
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_valid <= 1'b0;
      sample_forced <= 1'b0;
      sample_dig_only <= 1'b0;
      sample_dio <= 9'h000;
      sample_adc <= 60'h0;
      tx_send <= 1'b0;
      samp_n_q <= 8'h00;
    end else begin
      sample_valid <= per_take || st_q == RIO_SEND || (force_cmd && any_in);
      sample_forced <= force_cmd && any_in;
      sample_dig_only <= st_q == RIO_SEND;
      sample_dio <= line_in & di_en;
      sample_adc <= (st_q == RIO_SEND) ? 60'h0 : sample_adc_d;
      tx_send <= (st_q == RIO_FLUSH && samp_n_q != 8'h00) ||
                 st_q == RIO_SEND || (per_take && batch_full);
      if (st_q == RIO_FLUSH || (per_take && batch_full)) samp_n_q <= 8'h00;
      else if (per_take) samp_n_q <= samp_n_q + 8'h01;
    end
  end

  // Command answer one cycle after the request
  logic [63:0] rd_d;
  assign rd_d =
    is_line ? {61'h0, cfg_q[line_sel]} :
    (cmd_id == `RIO_ID_FWD_EN)    ? {63'h0, fwd_en_q} :
    (cmd_id == `RIO_ID_SAMP_TX)   ? {56'h0, samp_tx_q} :
    (cmd_id == `RIO_ID_CHG_MASK)  ? {56'h0, chg_mask_q} :
    (cmd_id == `RIO_ID_SAMP_INT)  ? {48'h0, samp_int_q} :
    (cmd_id == `RIO_ID_BOUND_ADR) ? bound_q :
    is_tmo                        ? {56'h0, tmo_q[cmd_id[2:0]]} :
    (cmd_id == `RIO_ID_PWM_A_FN)  ? {62'h0, pwm_fn_q[0]} :
    (cmd_id == `RIO_ID_PWM_B_FN)  ? {62'h0, pwm_fn_q[1]} :
    (cmd_id == `RIO_ID_PWM_A_LVL) ? {54'h0, pwm_lvl_q[0]} :
    (cmd_id == `RIO_ID_PWM_B_LVL) ? {54'h0, pwm_lvl_q[1]} :
    (cmd_id == `RIO_ID_PWM_TMO)   ? {56'h0, pwm_tmo_q} :
    (cmd_id == `RIO_ID_RSSI_TMR)  ? {56'h0, rssi_tmr_q} :
    (cmd_id == `RIO_ID_API_MODE)  ? {62'h0, api_q} :
    force_cmd                     ? {55'h0, line_in & di_en} : 64'h0;
  // Reads of the write-only level and of unknown identifiers are errors
  wire rd_bad = !cmd_write && (cmd_id == `RIO_ID_OUT_LVL ||
                (cmd_id[4:3] == 2'b01 && cmd_id > `RIO_ID_BOUND_ADR) ||
                (force_cmd && !any_in));
  always_ff @(posedge clock) begin
    resp_valid <= !rst && cmd_valid;
    resp_error <= !rst && cmd_valid &&
                  (cmd_write ? !wr_ok : rd_bad);
    resp_rdata <= (rst || cmd_write) ? 64'h0 : rd_d;
  end

  sequence s_flush;
    st_q == RIO_FLUSH;
  endsequence
  sequence s_digital_sent;
    sample_valid && sample_dig_only && tx_send;
  endsequence
  a_change_after_queue: assert property (@(posedge clock)
    disable iff (rst) s_flush |=> ##1 s_digital_sent)
    else $error("change sample not sent after queue flush");
  a_block_all_src: assert property (@(posedge clock)
    disable iff (rst)
    (rx_io_valid && bound_q == `RIO_RST_BOUND) |-> !accept)
    else $error("all-ones bound address accepted a packet");
  a_accept_any_src: assert property (@(posedge clock)
    disable iff (rst)
    (rx_io_valid && bound_q == `RIO_ANY_SOURCE) |-> accept)
    else $error("wildcard bound address refused a packet");
  a_forward_rx_io: assert property (@(posedge clock)
    disable iff (rst) rx_io_valid |=> fwd_valid == $past(fwd_en_q))
    else $error("received I/O data forwarding wrong");
  a_refuse_bad_pwm: assert property (@(posedge clock)
    disable iff (rst)
    (wr && cmd_id == `RIO_ID_PWM_A_FN && cmd_wdata == 64'h3) |=>
      (resp_error && $stable(pwm_fn_q[0])))
    else $error("illegal PWM function write accepted");
  a_force_no_input: assert property (@(posedge clock)
    disable iff (rst)
    (force_cmd && !any_in) |=> (resp_valid && resp_error && !sample_valid))
    else $error("forced sample without inputs not refused");
  a_input_only_cfg: assert property (@(posedge clock)
    disable iff (rst) cfg_q[8] == `RIO_CFG_OFF || cfg_q[8] == `RIO_CFG_DI)
    else $error("input-only line holds an unavailable setting");
  a_pwm_expiry_zero: assert property (@(posedge clock)
    disable iff (rst)
    (pwm_exp && !pwm_take) |=> (pwm_lvl_q[0] == 10'h000 &&
                                pwm_lvl_q[1] == 10'h000 && !pwm_act_q))
    else $error("PWM level not zeroed at timeout");
  a_tx_enable_high: assert property (@(posedge clock)
    disable iff (rst) (cfg_q[7] == `RIO_CFG_TXEN_HI) |=>
      (line_oe[7] && line_out[7] == $past(serial_tx_active)))
    else $error("transmit enable does not follow serial activity");
  a_rssi_off: assert property (@(posedge clock)
    disable iff (rst)
    (!rssi_act_q && pwm_fn_q[0] == `RIO_PWM_RSSI) |=> !pwm_out[0])
    else $error("strength output active after its timer expired");

endmodule : rio_line_ctrl
`default_nettype wire

// ---- pkg/rio_map.svh ----
// Offsets, field codes, reset values and timing counts of the I/O line block
`ifndef RIO_MAP_SVH
`define RIO_MAP_SVH
// Parameter identifiers on the command port; lines 0..8 use their number
`define RIO_ID_LINE_LAST  5'h08
`define RIO_ID_FWD_EN     5'h09
`define RIO_ID_SAMP_TX    5'h0a
`define RIO_ID_OUT_LVL    5'h0b
`define RIO_ID_CHG_MASK   5'h0c
`define RIO_ID_SAMP_INT   5'h0d
`define RIO_ID_BOUND_ADR  5'h0e
`define RIO_ID_TMO_BASE   5'h10
`define RIO_ID_PWM_A_FN   5'h18
`define RIO_ID_PWM_B_FN   5'h19
`define RIO_ID_PWM_A_LVL  5'h1a
`define RIO_ID_PWM_B_LVL  5'h1b
`define RIO_ID_PWM_TMO    5'h1c
`define RIO_ID_RSSI_TMR   5'h1d
`define RIO_ID_API_MODE   5'h1e
`define RIO_ID_FORCE      5'h1f
// Line setting codes
`define RIO_CFG_OFF       3'h0
`define RIO_CFG_SPECIAL   3'h1
`define RIO_CFG_ADC       3'h2
`define RIO_CFG_DI        3'h3
`define RIO_CFG_DO_LO     3'h4
`define RIO_CFG_DO_HI     3'h5
`define RIO_CFG_TXEN_LO   3'h6
`define RIO_CFG_TXEN_HI   3'h7
// PWM pin functions and API modes
`define RIO_PWM_OFF       2'h0
`define RIO_PWM_RSSI      2'h1
`define RIO_PWM_OUT       2'h2
`define RIO_API_ESC       2'h2
// Reset values, the wildcard source address and the PWM maximum level
`define RIO_RST_LINE7     3'h1
`define RIO_RST_LINE5     3'h1
`define RIO_RST_FWD_EN    1'h1
`define RIO_RST_SAMP_TX   8'h01
`define RIO_RST_TMO       8'hff
`define RIO_RST_PWM_A_FN  2'h1
`define RIO_RST_RSSI_TMR  8'h28
`define RIO_RST_BOUND     64'hffff_ffff_ffff_ffff
`define RIO_ANY_SOURCE    64'h0000_0000_0000_ffff
`define RIO_PWM_MAX       10'h3ff
// Timing: clock period, unit times and derived cycle counts
`define RIO_CLK_NS        5
`define RIO_MS_NS         1000000
`define RIO_TMO_UNIT_MS   100
`define RIO_MS_CYCLES     (`RIO_MS_NS / `RIO_CLK_NS)
`define RIO_TMO_CYCLES    (`RIO_TMO_UNIT_MS * `RIO_MS_CYCLES)
`endif

// ---- pkg/rio_pkg.sv ----
// Types shared by the I/O line block
`default_nettype none
package rio_pkg;
  typedef logic [2:0] rio_cfg_t;
  // Change-detect sequencer, one-hot
  typedef enum logic [2:0] {
    RIO_IDLE  = 3'b001,
    RIO_FLUSH = 3'b010,
    RIO_SEND  = 3'b100
  } rio_chg_t;
endpackage : rio_pkg
`default_nettype wire

// ---- dv/rio_remote_model.sv ----
// Remote radio model that delivers received I/O packets
`timescale 1ns/100ps
`default_nettype none
module rio_remote_model (
  input  wire logic        clock,
  output logic             rx_pkt_valid,
  output logic [9:0]       rx_rssi,
  output logic             rx_io_valid,
  output logic [63:0]      rx_io_src,
  output logic [7:0]       rx_io_dout,
  output logic             rx_io_pwm_valid,
  output logic [19:0]      rx_io_pwm
);
  // Quiet lines at time zero
  initial begin
    {rx_pkt_valid, rx_io_valid, rx_io_pwm_valid} = 3'h0;
    {rx_rssi, rx_io_src, rx_io_dout, rx_io_pwm} = '0;
  end
  // One packet per call; payload inverted after it so stale data never matches
  task send(input logic [63:0] src, input logic [7:0] dout);
    @(negedge clock);
    {rx_pkt_valid, rx_io_valid} = 2'h3;
    rx_io_src  = src;
    rx_io_dout = dout;
    rx_rssi    = 10'h155;
    @(negedge clock);
    {rx_pkt_valid, rx_io_valid} = 2'h0;
    rx_io_src  = ~src;
    rx_io_dout = ~dout;
  endtask : send
  // PWM levels from a remote, pin A in the low ten bits
  task send_pwm(input logic [19:0] lvl);
    @(negedge clock);
    rx_io_pwm_valid = 1'h1;
    rx_io_pwm       = lvl;
    @(negedge clock);
    rx_io_pwm_valid = 1'h0;
    rx_io_pwm       = ~lvl;
  endtask : send_pwm
endmodule : rio_remote_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the I/O line block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clock = 0, rst = 1, cmd_valid = 0, cmd_write = 0;
  logic        serial_tx_active = 0;
  logic [4:0]  cmd_id = '0;
  logic [63:0] cmd_wdata = '0, resp_rdata, rx_io_src;
  logic [8:0]  line_in = '0, sample_dio;
  logic [59:0] sample_adc, adc_in = '0;
  logic [9:0]  rx_rssi;
  logic [19:0] rx_io_pwm;
  logic [7:0]  line_out, line_oe, fwd_dio, rx_io_dout;
  logic [1:0]  api_mode, pwm_out;
  logic        resp_valid, resp_error, rts_hold, fwd_valid, fwd_escaped;
  logic        sample_valid, sample_forced, sample_dig_only, tx_send;
  logic        rx_pkt_valid, rx_io_valid, rx_io_pwm_valid;
  int          n_errors = 0, check_count = 0, i;
  // Shortened ms and 100 ms counts keep the timeout runs brief
  rio_line_ctrl #(.MS_CYCLES(4), .TMO_CYCLES(8)) rio_line_ctrl_i (
    .clock, .rst, .cmd_valid, .cmd_write, .cmd_id, .cmd_wdata,
    .resp_valid, .resp_error, .resp_rdata, .line_in, .adc_in,
    .line_out, .line_oe, .associated(1'h0), .serial_rx_full(1'h0),
    .serial_tx_active, .rts_hold, .api_mode, .rx_pkt_valid,
    .rx_rssi, .rx_io_valid, .rx_io_src, .rx_io_dout, .rx_io_pwm_valid,
    .rx_io_pwm, .fwd_valid, .fwd_escaped, .fwd_dio, .sample_valid,
    .sample_forced, .sample_dig_only, .sample_dio, .sample_adc,
    .tx_send, .pwm_out);
  rio_remote_model rio_remote_model_i (.clock, .rx_pkt_valid, .rx_rssi,
    .rx_io_valid, .rx_io_src, .rx_io_dout, .rx_io_pwm_valid, .rx_io_pwm);
  // 200 MHz clock
  always #2.5 clock = ~clock;
  task chk(input logic c, input string m);
    check_count++;
    if (c !== 1'h1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // Idle cycle first so valid is never raised and dropped in one step
  task cmd(input logic w, input logic [4:0] id, input logic [63:0] d,
           input logic e, input logic [63:0] x);
    @(negedge clock);
    cmd_valid = 1;
    cmd_write = w;
    cmd_id    = id;
    cmd_wdata = d;
    @(negedge clock);
    cmd_valid = 0;
    chk(resp_valid === 1'h1 && resp_error === e, "response");
    if (!e) chk(resp_rdata === x, "read data");
  endtask : cmd
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Watchdog, far beyond the expected run of about 300 cycles
  initial begin
    #50000;
    n_errors++;
    stop_test;
  end
  // Test sequence
  initial begin
    repeat (8) @(negedge clock);
    rst = 0;
    cmd(0, 5'h07, '0, 0, 64'h1);
    cmd(0, 5'h05, '0, 0, 64'h1);
    cmd(0, 5'h06, '0, 0, 64'h0);
    cmd(0, 5'h08, '0, 0, 64'h0);
    cmd(0, 5'h00, '0, 0, 64'h0);
    cmd(0, 5'h09, '0, 0, 64'h1);
    cmd(0, 5'h0a, '0, 0, 64'h1);
    cmd(0, 5'h0c, '0, 0, 64'h0);
    cmd(0, 5'h0d, '0, 0, 64'h0);
    cmd(0, 5'h0e, '0, 0, '1);
    cmd(0, 5'h10, '0, 0, 64'hff);
    cmd(0, 5'h1c, '0, 0, 64'hff);
    cmd(0, 5'h18, '0, 0, 64'h1);
    cmd(0, 5'h19, '0, 0, 64'h0);
    cmd(0, 5'h1d, '0, 0, 64'h28);
    cmd(0, 5'h1e, '0, 0, 64'h0);
    $display("test reset values done");
    // Every code once; unavailable ones refused, last legal value kept
    for (i = 0; i < 8; i++) begin
      cmd(1, 5'h07, i, i == 2, '0);
      cmd(1, 5'h06, i, i == 2 || i > 5, '0);
      cmd(1, 5'h05, i, i > 5, '0);
      cmd(1, 5'h00, i, i == 1 || i > 5, '0);
      cmd(1, 5'h08, i, i != 0 && i != 3, '0);
      cmd(1, 5'h18, i, i > 2, '0);
      cmd(1, 5'h1e, i, i > 2, '0);
    end
    cmd(0, 5'h06, '0, 0, 64'h5);
    chk(line_oe[0] === 1'h1 && line_out[6:5] === 2'h3, "drive high");
    cmd(1, 5'h0a, '0, 1, '0);
    cmd(1, 5'h1a, 64'h400, 1, '0);
    cmd(1, 5'h1a, 64'h3ff, 0, '0);
    cmd(0, 5'h1a, '0, 0, 64'h3ff);
    cmd(0, 5'h0b, '0, 1, '0);
    cmd(1, 5'h0b, '0, 0, '0);
    repeat (2) @(negedge clock);
    chk(line_out[0] === 1'h0, "output level");
    // Line seven is left in active-high transmit enable by the loop
    serial_tx_active = 1;
    repeat (2) @(negedge clock);
    chk(line_oe[7] === 1'h1 && line_out[7] === 1'h1, "tx enable");
    serial_tx_active = 0;
    repeat (2) @(negedge clock);
    chk(line_out[7] === 1'h0, "tx enable off");
    $display("test settings done");
    // Forced sample: refused with no inputs, then reports line 8
    cmd(1, 5'h08, '0, 0, '0);
    cmd(0, 5'h1f, '0, 1, '0);
    line_in = 9'h102;
    cmd(1, 5'h08, 64'h3, 0, '0);
    cmd(0, 5'h1f, '0, 0, 64'h100);
    chk(sample_valid === 1'h1 && sample_forced === 1'h1, "forced");
    $display("test forced sample done");
    // Line passing from any source, timeout back to the low default
    cmd(1, 5'h00, 64'h4, 0, '0);
    cmd(1, 5'h0e, 64'hffff, 0, '0);
    cmd(1, 5'h10, 64'h3, 0, '0);
    rio_remote_model_i.send(64'h1234, 8'h01);
    chk(fwd_valid === 1'h1 && fwd_dio === 8'h01, "forward");
    chk(fwd_escaped === 1'h1 && api_mode === 2'h2, "escaped frame");
    @(negedge clock);
    chk(line_out[0] === 1'h1, "passed level");
    repeat (40) @(negedge clock);
    chk(line_out[0] === 1'h0, "timeout restore");
    cmd(1, 5'h0e, '1, 0, '0);
    rio_remote_model_i.send(64'h1234, 8'h01);
    repeat (2) @(negedge clock);
    chk(line_out[0] === 1'h0, "blocked source");
    // Passed PWM level, zeroed by the shared timeout of one unit
    cmd(1, 5'h0e, 64'hffff, 0, '0);
    cmd(1, 5'h1c, 64'h1, 0, '0);
    rio_remote_model_i.send_pwm(20'h00005);
    cmd(0, 5'h1a, '0, 0, 64'h5);
    repeat (24) @(negedge clock);
    cmd(0, 5'h1a, '0, 0, 64'h0);
    chk(pwm_out === 2'h0, "pwm off");
    $display("test line passing done");
    // Periodic sample every 2 ms, sent at once with one per transmit
    cmd(1, 5'h01, 64'h3, 0, '0);
    cmd(1, 5'h02, 64'h2, 0, '0);
    adc_in = {6{10'h2a5}};
    cmd(1, 5'h0d, 64'h2, 0, '0);
    for (i = 0; i < 40 && sample_valid !== 1'h1; i++) @(negedge clock);
    chk(tx_send === 1'h1 && sample_dio === 9'h102, "periodic");
    chk(sample_adc === 60'h2a50_0000, "periodic adc");
    cmd(1, 5'h0d, '0, 0, '0);
    cmd(1, 5'h0c, 64'h2, 0, '0);
    line_in = 9'h100;
    for (i = 0; i < 12 && sample_valid !== 1'h1; i++) @(negedge clock);
    chk(sample_dig_only === 1'h1 && tx_send === 1'h1, "change");
    chk(sample_dio === 9'h100 && sample_adc === 60'h0, "change data");
    $display("test sampling done");
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
